//--- hw/epv_exception_unit.sv
// Exception prioritiser and vectoring unit with an APB register slave.
// Assumes the core accepts requests, stacks state and signals returns.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/10ps
`include "epv_consts.svh"
module epv_exception_unit import epv_pkg::*; #(
  parameter int NEST = 10,
  parameter int PRI_BITS = 3
) (
  input wire logic pclk, // Core clock.
  input wire logic presetn, // Power-up or warm reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error.
  input wire logic [47:0] irq_in, // Peripheral requests.
  input wire logic nmi_in, // Non-maskable request.
  input wire logic debug_event, // Non-halting debug event.
  input wire logic svc_exec, // Supervisor call executed.
  input wire logic systick_zero, // System timer reached zero.
  input wire logic systick_int_en, // System timer interrupt enable.
  input wire epv_fault_t fault, // Fault causes.
  output epv_core_req_t exc_req, // Exception request to core.
  input wire logic exc_accept, // Core takes the request.
  input wire logic exc_return, // Core finished a handler.
  output epv_fetch_t fetch, // Fetch and stacking command.
  output logic core_run, // Core may execute.
  output logic thread_mode, // Core is in thread mode.
  output logic privileged // Core runs privileged.
);
  logic [63:0] pend, next_pend; // Pending state per exception.
  logic [63:0] act, next_act; // Active state per exception.
  logic [63:0] en_irq, next_en_irq; // Interrupt enables.
  logic [9:0] hnd_ctrl, next_hnd_ctrl; // Handler control.
  logic [1:0] grp, next_grp; // Subpriority bit count.
  logic [31:0] vt_base, next_vt_base; // Vector table base.
  logic rd_wait, next_rd_wait; // Read data stage.
  logic [31:0] next_prdata; // Next read data.
  logic [5:0] stk_num [NEST]; // Nested exception numbers.
  logic [3:0] stk_lvl [NEST]; // Nested group levels.
  logic [5:0] next_stk_num [NEST]; // Next numbers.
  logic [3:0] next_stk_lvl [NEST]; // Next levels.
  logic [3:0] sp, next_sp; // Nesting depth.
  logic [5:0] scan_idx, next_scan_idx; // Index being read.
  logic [5:0] cur_idx, next_cur_idx; // Index whose data is back.
  logic cur_ok, next_cur_ok; // Data stage valid.
  logic best_ok, next_best_ok; // Candidate found this sweep.
  logic [5:0] best_num, next_best_num; // Candidate number.
  logic [3:0] best_lvl, next_best_lvl; // Candidate full level.
  logic [3:0] best_glvl, next_best_glvl; // Candidate group level.
  logic win_ok, next_win_ok; // Winner latched.
  logic [5:0] win_num, next_win_num; // Winner number.
  logic [3:0] win_glvl, next_win_glvl; // Winner group level.
  logic tail, next_tail; // State still stacked after return.
  epv_boot_t boot, next_boot; // Boot step.
  epv_fetch_t next_fetch; // Next fetch command.
  logic [PRI_BITS-1:0] pri_scan, pri_bus; // Store read data.
  logic wr, rd_acc, pri_page, pri_wr; // Bus decode terms.
  logic [63:0] en_all, set_v, clr_v; // Combined vectors.
  logic [3:0] cur_lvl; // Running group level.
  logic mem_req, bus_req, use_req; // Fault requests.
  localparam logic [63:0] PROG_MASK = `EPV_PROG_MASK; // Writable levels.

  if (NEST < 10 || PRI_BITS != 3) begin : g_bad_param
    $error("Nesting must cover ten levels with 3-bit priorities.");
  end

  // Places a 32-bit interrupt word onto the exception numbering.
  function automatic logic [63:0] irq_word(input logic hi,
                                           input logic [31:0] d);
    irq_word = hi ? {d[15:0], 48'h0} : {16'h0, d, 16'h0};
  endfunction

  // Full level: fixed ranks first, then programmable values.
  function automatic logic [3:0] lvl_of(input logic [5:0] n,
                                        input logic [2:0] p,
                                        input logic [1:0] g,
                                        input logic group_only);
    logic [2:0] m;
    m = group_only ? (3'h7 << g) : 3'h7;
    if (n == `EPV_EXC_NMI) lvl_of = `EPV_LVL_NMI;
    else if (n == `EPV_EXC_HARD) lvl_of = `EPV_LVL_HARD;
    else lvl_of = {1'b0, p & m} + `EPV_LVL_PROG;
  endfunction

  assign wr = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign pri_page = paddr[11:8] == `EPV_OFF_PRI_PAGE;
  assign pri_wr = wr & pri_page & PROG_MASK[paddr[7:2]];
  assign pready = pwrite | rd_wait;
  assign cur_lvl = (sp == 4'h0) ? `EPV_LVL_THREAD : stk_lvl[sp - 4'h1];

  epv_pri_mem #(.DEPTH(64), .WIDTH(PRI_BITS)) u_pri (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(pri_wr),
    .wr_addr(paddr[7:2]),
    .wr_data(pwdata[PRI_BITS-1:0]),
    .rd_addr_a(scan_idx),
    .rd_data_a(pri_scan),
    .rd_addr_b(paddr[7:2]),
    .rd_data_b(pri_bus)
  );

  // Enables, escalation and request sources.
  always_comb begin
    en_all = en_irq;
    en_all[`EPV_EXC_NMI] = 1'b1;
    en_all[`EPV_EXC_HARD] = 1'b1;
    en_all[`EPV_EXC_MEM] = hnd_ctrl[0];
    en_all[`EPV_EXC_BUS] = hnd_ctrl[1];
    en_all[`EPV_EXC_USAGE] = hnd_ctrl[2];
    en_all[`EPV_EXC_SVC] = hnd_ctrl[3];
    en_all[`EPV_EXC_DBG] = hnd_ctrl[4];
    en_all[`EPV_EXC_PSR] = hnd_ctrl[5];
    en_all[`EPV_EXC_TICK] = hnd_ctrl[6];
    // execute-never aborts ignore the protection unit
    mem_req = fault.mem_viol | fault.execute_never_fetch;
    bus_req = fault.bus_precise | fault.bus_imprecise;
    use_req = fault.undef | fault.unalign_ill | fault.bad_state |
              fault.bad_return |
              (fault.unalign_any & hnd_ctrl[`EPV_HC_TRAP_UA]) |
              (fault.div_zero & hnd_ctrl[`EPV_HC_TRAP_DZ]);
    set_v = '0;
    set_v[63:16] = irq_in;
    set_v[`EPV_EXC_NMI] = nmi_in |
      (wr && paddr == `EPV_OFF_CTRL_STATE && pwdata[`EPV_CS_NMI_SET]);
    set_v[`EPV_EXC_MEM] = mem_req & hnd_ctrl[0];
    set_v[`EPV_EXC_BUS] = bus_req & hnd_ctrl[1];
    set_v[`EPV_EXC_USAGE] = use_req & hnd_ctrl[2];
    // entry errors and disabled faults escalate
    set_v[`EPV_EXC_HARD] = fault.entry_error |
      (mem_req & ~hnd_ctrl[0]) | (bus_req & ~hnd_ctrl[1]) |
      (use_req & ~hnd_ctrl[2]);
    set_v[`EPV_EXC_SVC] = svc_exec;
    set_v[`EPV_EXC_DBG] = debug_event & hnd_ctrl[4];
    set_v[`EPV_EXC_PSR] = wr && paddr == `EPV_OFF_CTRL_STATE &&
                          pwdata[`EPV_CS_PSR_SET];
    set_v[`EPV_EXC_TICK] = (systick_zero & systick_int_en) |
      (wr && paddr == `EPV_OFF_CTRL_STATE && pwdata[`EPV_CS_TICK_SET]);
    if (wr && paddr[11:3] == `EPV_OFF_SET_PND0 >> 3) begin
      set_v = set_v | irq_word(paddr[2], pwdata);
    end
    set_v = set_v & `EPV_VALID_MASK;
    clr_v = '0;
    if (wr && paddr[11:3] == `EPV_OFF_CLR_PND0 >> 3) begin
      clr_v = irq_word(paddr[2], pwdata);
    end
    if (wr && paddr == `EPV_OFF_CTRL_STATE) begin
      clr_v[`EPV_EXC_PSR] = pwdata[`EPV_CS_PSR_CLR];
      clr_v[`EPV_EXC_TICK] = pwdata[`EPV_CS_TICK_CLR];
    end
    if (exc_accept && exc_req.valid) begin
      clr_v[exc_req.num] = 1'b1;
    end
  end

  // Register file next values and read data.
  always_comb begin
    next_en_irq = en_irq;
    next_hnd_ctrl = hnd_ctrl;
    next_grp = grp;
    next_vt_base = vt_base;
    next_rd_wait = rd_acc & ~rd_wait;
    next_prdata = prdata;
    pslverr = 1'b0;
    if (wr) begin
      case (paddr)
        `EPV_OFF_SET_EN0, `EPV_OFF_SET_EN1: begin
          next_en_irq = en_irq | (irq_word(paddr[2], pwdata) &
                                  `EPV_VALID_MASK);
        end
        `EPV_OFF_CLR_EN0, `EPV_OFF_CLR_EN1: begin
          next_en_irq = en_irq & ~irq_word(paddr[2], pwdata);
        end
        `EPV_OFF_HND_CTRL: next_hnd_ctrl = pwdata[9:0];
        `EPV_OFF_GROUP: next_grp = pwdata[1:0];
        `EPV_OFF_VT_BASE: next_vt_base = {pwdata[31:8], 8'h00};
        `EPV_OFF_SET_PND0, `EPV_OFF_SET_PND1, `EPV_OFF_CLR_PND0,
        `EPV_OFF_CLR_PND1, `EPV_OFF_CTRL_STATE: begin
          next_vt_base = vt_base;
        end
        default: pslverr = ~pri_page;
      endcase
    end
    if (rd_acc && !rd_wait) begin
      case (paddr)
        `EPV_OFF_SET_EN0, `EPV_OFF_CLR_EN0: next_prdata = en_irq[47:16];
        `EPV_OFF_SET_EN1, `EPV_OFF_CLR_EN1: begin
          next_prdata = {16'h0, en_irq[63:48]};
        end
        `EPV_OFF_SET_PND0, `EPV_OFF_CLR_PND0: next_prdata = pend[47:16];
        `EPV_OFF_SET_PND1, `EPV_OFF_CLR_PND1: begin
          next_prdata = {16'h0, pend[63:48]};
        end
        `EPV_OFF_CTRL_STATE: begin
          next_prdata = '0;
          next_prdata[`EPV_CS_NMI_SET] = pend[`EPV_EXC_NMI];
          next_prdata[`EPV_CS_PSR_SET] = pend[`EPV_EXC_PSR];
          next_prdata[`EPV_CS_TICK_SET] = pend[`EPV_EXC_TICK];
          next_prdata[`EPV_CS_IRQ_PEND] = |pend[63:16];
          next_prdata[17:12] = win_ok ? win_num : 6'h00;
          next_prdata[5:0] = (sp == 4'h0) ? 6'h00 : stk_num[sp - 4'h1];
        end
        `EPV_OFF_HND_CTRL: next_prdata = {22'h0, hnd_ctrl};
        `EPV_OFF_GROUP: next_prdata = {30'h0, grp};
        `EPV_OFF_VT_BASE: next_prdata = vt_base;
        `EPV_OFF_ACTIVE0: next_prdata = act[31:0];
        `EPV_OFF_ACTIVE1: next_prdata = act[63:32];
        // Priority words return the stored value in the low bits.
        default: next_prdata = pri_page ? {29'h0, pri_bus} : 32'h0;
      endcase
    end
    if (rd_acc && rd_wait && !pri_page && paddr > `EPV_OFF_ACTIVE1) begin
      pslverr = 1'b1;
    end
  end

  // Registers software state; enables start clear except SVC, service request and tick handlers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_irq <= '0;
      hnd_ctrl <= `EPV_HC_RESET;
      grp <= 2'h0;
      vt_base <= `EPV_VT_RESET;
      rd_wait <= 1'b0;
      prdata <= '0;
    end else begin
      en_irq <= next_en_irq;
      hnd_ctrl <= next_hnd_ctrl;
      grp <= next_grp;
      vt_base <= next_vt_base;
      rd_wait <= next_rd_wait;
      prdata <= next_prdata;
    end
  end

  // Sweeps all exceptions, keeping the best eligible one.
  always_comb begin
    logic [3:0] l;
    logic el;
    l = lvl_of(cur_idx, pri_scan, grp, 1'b0);
    el = cur_ok & pend[cur_idx] & en_all[cur_idx];
    next_scan_idx = (scan_idx == `EPV_EXC_LAST) ? `EPV_EXC_FIRST :
                    scan_idx + 6'h01;
    next_cur_idx = scan_idx;
    next_cur_ok = 1'b1;
    next_best_ok = best_ok;
    next_best_num = best_num;
    next_best_lvl = best_lvl;
    next_best_glvl = best_glvl;
    next_win_ok = win_ok;
    next_win_num = win_num;
    next_win_glvl = win_glvl;
    if (el && (!best_ok || l < best_lvl)) begin
      next_best_ok = 1'b1;
      next_best_num = cur_idx;
      next_best_lvl = l;
      next_best_glvl = lvl_of(cur_idx, pri_scan, grp, 1'b1);
    end
    if (cur_ok && cur_idx == `EPV_EXC_LAST) begin
      next_win_ok = next_best_ok && next_best_glvl < cur_lvl;
      next_win_num = next_best_num;
      next_win_glvl = next_best_glvl;
      next_best_ok = 1'b0;
    end
    if (exc_accept || exc_return) begin
      next_win_ok = 1'b0;
    end
  end

  // Registers the sweep.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_idx <= `EPV_EXC_FIRST;
      cur_idx <= `EPV_EXC_FIRST;
      cur_ok <= 1'b0;
      best_ok <= 1'b0;
      best_num <= 6'h00;
      best_lvl <= 4'h0;
      best_glvl <= 4'h0;
      win_ok <= 1'b0;
      win_num <= 6'h00;
      win_glvl <= 4'h0;
    end else begin
      scan_idx <= next_scan_idx;
      cur_idx <= next_cur_idx;
      cur_ok <= next_cur_ok;
      best_ok <= next_best_ok;
      best_num <= next_best_num;
      best_lvl <= next_best_lvl;
      best_glvl <= next_best_glvl;
      win_ok <= next_win_ok;
      win_num <= next_win_num;
      win_glvl <= next_win_glvl;
    end
  end

  // Request to the core; it may retire an instruction meanwhile.
  always_comb begin
    // request is offered, core picks its boundary
    exc_req.valid = core_run & win_ok & pend[win_num] & en_all[win_num];
    exc_req.tail = tail;
    exc_req.num = win_num;
    exc_req.addr = vt_base + {24'h0, win_num, 2'b00};
  end

  // Exception states, nesting, boot and fetch commands.
  always_comb begin
    // pending and active are independent bits
    next_pend = (pend & ~clr_v) | set_v;
    next_act = act;
    next_sp = sp;
    next_stk_num = stk_num;
    next_stk_lvl = stk_lvl;
    next_tail = tail;
    next_boot = boot;
    next_fetch = '0;
    case (boot)
      EPV_BOOT_SP: begin
        next_fetch.valid = 1'b1;
        next_fetch.sp = 1'b1;
        next_fetch.addr = vt_base;
        next_boot = EPV_BOOT_VEC;
      end
      EPV_BOOT_VEC: begin
        next_fetch.valid = 1'b1;
        next_fetch.addr = vt_base + {24'h0, `EPV_EXC_RESET, 2'b00};
        next_boot = EPV_BOOT_RUN;
      end
      EPV_BOOT_RUN: next_boot = EPV_BOOT_RUN;
      default: next_boot = EPV_BOOT_SP;
    endcase
    if (exc_accept && exc_req.valid) begin
      next_act[exc_req.num] = 1'b1;
      next_stk_num[sp] = exc_req.num;
      next_stk_lvl[sp] = win_glvl;
      next_sp = sp + 4'h1;
      // stacking runs alongside the vector fetch
      next_fetch.valid = 1'b1;
      next_fetch.save = ~tail;
      next_fetch.addr = exc_req.addr;
      next_tail = 1'b0;
    end else if (exc_return && sp != 4'h0) begin
      next_act[stk_num[sp - 4'h1]] = 1'b0;
      next_sp = sp - 4'h1;
      // keep frame stacked for a chained handler
      next_tail = 1'b1;
    end else if (cur_ok && cur_idx == `EPV_EXC_LAST && !next_win_ok) begin
      next_tail = 1'b0;
    end
  end

  // reset halts the core and clears every exception state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= '0;
      act <= '0;
      sp <= 4'h0;
      for (int i = 0; i < NEST; i++) begin
        stk_num[i] <= 6'h00;
        stk_lvl[i] <= 4'h0;
      end
      tail <= 1'b0;
      boot <= EPV_BOOT_SP;
      fetch <= '0;
    end else begin
      pend <= next_pend;
      act <= next_act;
      sp <= next_sp;
      stk_num <= next_stk_num;
      stk_lvl <= next_stk_lvl;
      tail <= next_tail;
      boot <= next_boot;
      fetch <= next_fetch;
    end
  end

  // run privileged in thread mode once booted.
  assign core_run = boot == EPV_BOOT_RUN;
  assign thread_mode = sp == 4'h0;
  assign privileged = core_run;
endmodule // epv_exception_unit

//--- common/epv_consts.svh
// Offsets, field positions, reset values and fixed levels of the
// exception unit. Assumes a 12-bit APB byte address.
//
// Behaviour
// - Eight priority levels, seven handlers, 30 interrupts.
// - Level 0 ranks after reset, NMI, hard fault.
// - Boot loads stack pointer, then reset vector.
// - Reset halts core; restart privileged thread mode.
// - NMI from pin or software, fixed top.
// - Entry errors and unhandled faults raise hard fault.
// - Protection faults, including execute-never fetches.
// - Bus fault enableable, precise or imprecise.
// - Usage fault causes, optional unaligned, divide.
// - Supervisor call instruction raises exception eleven.
// - Debug monitor only when enabled, normal preemption.
// - Pendable service request only by software write.
// - System tick from timer zero or software.
// - Interrupts from sixteen up, vectors from 0x40.
// - Fixed interrupt map with reserved numbers masked.
// - Inactive, pending, active, active and pending states.
// - Peripheral or software request makes interrupt pending.
// - Save state with parallel fetch; tail-chain.
// - Core may retire one instruction before entry.
// - Priority splits into group and subpriority.
// - Equal priority picks lowest exception number.
// - Preempt only on strictly higher group priority.
`ifndef EPV_CONSTS_SVH
`define EPV_CONSTS_SVH
`define EPV_OFF_SET_EN0 12'h000
`define EPV_OFF_SET_EN1 12'h004
`define EPV_OFF_CLR_EN0 12'h008
`define EPV_OFF_CLR_EN1 12'h00c
`define EPV_OFF_SET_PND0 12'h010
`define EPV_OFF_SET_PND1 12'h014
`define EPV_OFF_CLR_PND0 12'h018
`define EPV_OFF_CLR_PND1 12'h01c
`define EPV_OFF_CTRL_STATE 12'h020
`define EPV_OFF_HND_CTRL 12'h024
`define EPV_OFF_GROUP 12'h028
`define EPV_OFF_VT_BASE 12'h02c
`define EPV_OFF_ACTIVE0 12'h030
`define EPV_OFF_ACTIVE1 12'h034
`define EPV_OFF_PRI_PAGE 4'h1
`define EPV_CS_NMI_SET 31
`define EPV_CS_PSR_SET 28
`define EPV_CS_PSR_CLR 27
`define EPV_CS_TICK_SET 26
`define EPV_CS_TICK_CLR 25
`define EPV_CS_IRQ_PEND 22
`define EPV_HC_TRAP_UA 8
`define EPV_HC_TRAP_DZ 9
`define EPV_HC_RESET 10'h068
`define EPV_VT_RESET 32'h0000_0000
`define EPV_VALID_MASK 64'hc038_33ff_cfbf_d87c
`define EPV_PROG_MASK 64'hc038_33ff_cfbf_d870
`define EPV_EXC_RESET 6'h01
`define EPV_EXC_NMI 6'h02
`define EPV_EXC_HARD 6'h03
`define EPV_EXC_MEM 6'h04
`define EPV_EXC_BUS 6'h05
`define EPV_EXC_USAGE 6'h06
`define EPV_EXC_SVC 6'h0b
`define EPV_EXC_DBG 6'h0c
`define EPV_EXC_PSR 6'h0e
`define EPV_EXC_TICK 6'h0f
`define EPV_EXC_FIRST 6'h02
`define EPV_EXC_LAST 6'h3f
`define EPV_LVL_NMI 4'h0
`define EPV_LVL_HARD 4'h1
`define EPV_LVL_PROG 4'h2
`define EPV_LVL_THREAD 4'hf
`endif

//--- common/epv_pkg.sv
// Types shared by the exception unit, its core model, its checker and the bench.
// Assumes the constants header is compiled alongside.
package epv_pkg;
  // Request handed to the core.
  typedef struct packed {
    logic valid;
    logic tail;
    logic [5:0] num;
    logic [31:0] addr;
  } epv_core_req_t;
  // Fetch and stacking command to the core.
  typedef struct packed {
    logic valid;
    logic sp;
    logic save;
    logic [31:0] addr;
  } epv_fetch_t;
  // Fault causes reported by the core.
  typedef struct packed {
    logic mem_viol;
    logic execute_never_fetch;
    logic bus_precise;
    logic bus_imprecise;
    logic undef;
    logic unalign_ill;
    logic bad_state;
    logic bad_return;
    logic unalign_any;
    logic div_zero;
    logic entry_error;
  } epv_fault_t;
  // Boot sequence after reset.
  typedef enum logic [1:0] {
    EPV_BOOT_SP = 2'b00,
    EPV_BOOT_VEC = 2'b01,
    EPV_BOOT_RUN = 2'b10
  } epv_boot_t;
endpackage

//--- hw/epv_pri_mem.sv
// Small priority store, one word per exception number.
// Assumes a single clock; both read ports give registered data.
`timescale 1ns/10ps
module epv_pri_mem #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 3
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic wr_en, // Write strobe.
  input wire logic [5:0] wr_addr, // Write index.
  input wire logic [WIDTH-1:0] wr_data, // Write value.
  input wire logic [5:0] rd_addr_a, // Scan read index.
  output logic [WIDTH-1:0] rd_data_a, // Scan read data.
  input wire logic [5:0] rd_addr_b, // Bus read index.
  output logic [WIDTH-1:0] rd_data_b // Bus read data.
);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage words.
  logic [WIDTH-1:0] next_mem [DEPTH]; // Next contents.

  if (DEPTH != 64) begin : g_bad_depth
    $error("Priority store depth must be 64.");
  end

  // Computes the written contents.
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      next_mem[i] = mem[i];
    end
    if (wr_en) begin
      next_mem[wr_addr] = wr_data;
    end
  end

  // Every priority starts at level zero; reads are registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      rd_data_a <= '0;
      rd_data_b <= '0;
    end else begin
      mem <= next_mem;
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
    end
  end
endmodule // epv_pri_mem

//--- dv/epv_core_model.sv
// Core model: takes offers, ends handlers.
// Assumes one clock shared with the unit.
`timescale 1ns/10ps
module epv_core_model import epv_pkg::*; #(
  parameter int SLOW = 2, // Offer delay in cycles.
  parameter int HOLD = 24 // Cycles each handler runs.
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire epv_core_req_t exc_req, // Offered exception.
  output logic exc_accept, // Take pulse.
  output logic exc_return // Handler done pulse.
);
  int wait_c; // Offer wait.
  int run_c; // Handler run time.
  int depth; // Handlers in progress.
  // Takes offers late, then retires handlers one by one.
  // late entry
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_accept <= 1'b0;
      exc_return <= 1'b0;
      wait_c <= 0;
      run_c <= 0;
      depth <= 0;
    end else begin
      exc_accept <= 1'b0;
      exc_return <= 1'b0;
      run_c <= run_c + 1;
      if (exc_req.valid && !exc_accept && wait_c >= SLOW) begin
        exc_accept <= 1'b1;
        wait_c <= 0;
        run_c <= 0;
        depth <= depth + 1;
      end else if (exc_req.valid && !exc_accept) begin
        wait_c <= wait_c + 1;
      end else if (depth > 0 && run_c >= HOLD && !exc_return) begin
        exc_return <= 1'b1;
        run_c <= 0;
        depth <= depth - 1;
      end
    end
  end
endmodule // epv_core_model

//--- dv/epv_exception_unit_assertions.sv
// Port checker for the exception unit.
// Bound onto every unit instance.
`timescale 1ns/10ps
`include "epv_consts.svh"
module epv_exception_unit_assertions import epv_pkg::*; (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Direction.
  input wire logic pready, // Ready.
  input wire logic nmi_in, // NMI request.
  input wire epv_core_req_t exc_req, // Request.
  input wire logic exc_accept, // Take pulse.
  input wire epv_fetch_t fetch, // Fetch command.
  input wire logic core_run, // Core runs.
  input wire logic thread_mode, // Thread mode.
  input wire logic privileged // Privileged.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  localparam logic [63:0] VM = `EPV_VALID_MASK; // Numbers that exist.
  wire logic tk = exc_accept && exc_req.valid; // A taken request.
  property p_fetch; tk |=> fetch.valid && fetch.addr == $past(exc_req.addr)
    && fetch.save == !$past(exc_req.tail); endproperty
  a_fetch: assert property (p_fetch) else $error("bad fetch");
  property p_addr; exc_req.valid |-> exc_req.addr[7:0] == {exc_req.num, 2'b00};
  endproperty
  a_addr: assert property (p_addr) else $error("bad vector");
  property p_resv; exc_req.valid |-> VM[exc_req.num]; endproperty
  a_resv: assert property (p_resv) else $error("reserved taken");
  property p_boot; $rose(presetn) |=> fetch.valid && fetch.sp && fetch.addr == 0
    ##1 fetch.valid && !fetch.sp && fetch.addr == 32'h4 ##1 core_run;
  endproperty
  a_boot: assert property (p_boot) else $error("bad boot");
  property p_run; core_run |=> core_run && privileged; endproperty
  a_run: assert property (p_run) else $error("run lost");
  property p_thread; tk |=> !thread_mode; endproperty
  a_thread: assert property (p_thread) else $error("still thread");
  property p_wr; psel && penable && pwrite |-> pready; endproperty
  a_wr: assert property (p_wr) else $error("write waited");
  property p_nmi; $rose(nmi_in) && core_run |-> ##[1:300]
    exc_req.valid && exc_req.num == `EPV_EXC_NMI; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not offered");
  c_tail: cover property (exc_req.valid && exc_req.tail);
  c_nest: cover property (tk && !thread_mode);
  c_nmi: cover property (tk && exc_req.num == `EPV_EXC_NMI);
endmodule // epv_exception_unit_assertions
bind epv_exception_unit epv_exception_unit_assertions i_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .pready, .nmi_in, .exc_req, .exc_accept, .fetch,
  .core_run, .thread_mode, .privileged);

//--- dv/exception_priority_vectoring_tb_top.sv
// Self-checking bench with a core model.
// Assumes package, design and checker compile first.
`timescale 1ns/10ps
`include "epv_consts.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module exception_priority_vectoring_tb_top import epv_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, nmi_in = 1'b0, svc_exec = 1'b0, systick_zero = 1'b0;
  logic debug_event = 1'b0, systick_int_en = 1'b1, rerr;
  logic [11:0] paddr = 12'h000; // Bus address.
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, exc_accept, exc_return, core_run;
  logic thread_mode, privileged;
  logic [47:0] irq_in = 48'h0; // Peripheral lines.
  logic [37:0] took = '0; // Last take.
  epv_fault_t fault = '0;
  epv_core_req_t exc_req;
  epv_fetch_t fetch;
  int failures = 0, n_compared = 0, n_took = 0;
  initial begin
    forever #4 pclk = ~pclk;
  end
  epv_exception_unit i_epv_exception_unit (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_in, .nmi_in,
    .debug_event, .svc_exec, .systick_zero, .systick_int_en, .fault,
    .exc_req, .exc_accept, .exc_return, .fetch, .core_run, .thread_mode,
    .privileged);
  epv_core_model #(.SLOW(1)) i_epv_core_model (.pclk, .presetn, .exc_req,
    .exc_accept, .exc_return);
  // Records each take.
  always @(posedge pclk) begin
    if (exc_accept && exc_req.valid) begin
      took <= {exc_req.num, exc_req.addr};
      n_took <= n_took + 1;
    end
  end
  // One APB transfer, released after pready.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0);
    `CHK({rerr, rdat}, e)
  endtask
  // Checks the next take's number and vector.
  task automatic take(input logic [5:0] n);
    int c = n_took;
    repeat (600) if (n_took == c) @(posedge pclk);
    `CHK(took, {n, 24'h0, n, 2'b00})
  endtask
  task automatic pirq(input logic [47:0] m);
    irq_in <= m;
    @(posedge pclk);
    irq_in <= 48'h0;
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    `CHK({core_run, privileged, thread_mode}, 3'b001)
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK({core_run, privileged, thread_mode}, 3'b111)
  endtask
  // Defaults, a priority store, refused places.
  task automatic t_regs();
    rd(12'h140, 33'h0);
    rd(`EPV_OFF_HND_CTRL, 33'h068);
    wr(12'h140, 32'h7);
    rd(12'h140, 33'h7);
    wr(12'h11c, 32'h7);
    rd(12'h11c, 33'h0);
    rd(12'h03c, 33'h1_0000_0000);
  endtask
  // Interrupt ordering, software pends and disabling.
  task automatic t_irq();
    int c;
    wr(`EPV_OFF_SET_EN0, 32'h47);
    wr(12'h140, 32'h1);
    pirq(48'h3);
    take(6'd17);
    take(6'd16);
    wr(12'h140, 32'h0);
    pirq(48'h3);
    take(6'd16);
    take(6'd17);
    wr(`EPV_OFF_SET_PND0, 32'h4);
    take(6'd18);
    wr(`EPV_OFF_CLR_EN0, 32'h1);
    pirq(48'h1);
    wr(`EPV_OFF_SET_PND0, 32'h40);
    c = n_took;
    repeat (300) @(posedge pclk);
    `CHK(n_took, c)
    wr(`EPV_OFF_SET_EN0, 32'h1);
    take(6'd16);
  endtask
  // System exceptions and faults.
  task automatic t_sys();
    logic [5:0] nums [3] = '{`EPV_EXC_NMI, `EPV_EXC_PSR, `EPV_EXC_TICK};
    int bits [3] = '{`EPV_CS_NMI_SET, `EPV_CS_PSR_SET, `EPV_CS_TICK_SET};
    for (int i = 0; i < 3; i++) begin
      wr(`EPV_OFF_CTRL_STATE, 32'h1 << bits[i]);
      take(nums[i]);
    end
    for (int i = 0; i < 3; i++) begin
      {nmi_in, svc_exec, systick_zero} <= 3'b100 >> i;
      @(posedge pclk);
      {nmi_in, svc_exec, systick_zero} <= 3'b000;
      take(i == 1 ? `EPV_EXC_SVC : nums[i]);
    end
    fault.undef <= 1'b1;
    @(posedge pclk);
    fault <= '0;
    take(`EPV_EXC_HARD);
    wr(`EPV_OFF_HND_CTRL, 32'h069);
    fault.execute_never_fetch <= 1'b1;
    @(posedge pclk);
    fault <= '0;
    take(`EPV_EXC_MEM);
  endtask
  task automatic tally_and_finish();
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Cuts a hung run short.
  initial begin
    repeat (40000) @(posedge pclk);
    failures++;
    tally_and_finish();
  end
  initial begin
    do_reset();
    t_regs();
    t_irq();
    t_sys();
    do_reset();
    rd(12'h140, 33'h0);
    tally_and_finish();
  end
endmodule // exception_priority_vectoring_tb_top
